// *** bridge_gpio_port_alt_functions_test.sv ***
`timescale 1ns/1ns
module bridge_gpio_port_alt_functions_test;
  import gpio_port_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic usb_suspend = 1'b0;
  logic [NUM_PINS-1:0] pad, pin_out, pin_oe, pw, pvw;
  logic [NUM_PINS-1:0] ext_en = '0;
  logic [NUM_PINS-1:0] ext_val = '0;
  logic remote_wakeup;
  logic pin_change_pending;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] ov = 32'h7ff;
  logic [31:0] mlo = 32'h0;
  logic [31:0] mhi = 32'h124;
  logic [31:0] r;
  logic [31:0] dv;
  logic e;
  int c;

  gpio_port dut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .usb_suspend(usb_suspend), .pin_in(pad), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_weak_en(pw), .pull_very_weak_en(pvw),
    .remote_wakeup(remote_wakeup),
    .pin_change_pending(pin_change_pending));
  gpio_pad_model pads (.core_clk(core_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_en(pw), .ext_en(ext_en), .ext_val(ext_val),
    .pad(pad));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check_word(string nm, logic [31:0] ex, logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic check_count(string nm, int lo, int hi, int got);
    checks_done++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // one apb transfer; waits on pready, never on a fixed latency
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge core_clk);
    end
    if (n >= 20) miscompares++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    check_word(nm, ex, r);
  endtask

  task automatic set_ov(int p, logic v);
    ov[p] = v;
    apb(1'b1, OFS_OUT_VALUE, ov);
  endtask

  task automatic set_mode(int p, pin_mode_t m);
    if (p < 8) begin
      mlo[3*p +: 3] = m;
      apb(1'b1, OFS_MODE_LO, mlo);
    end else begin
      mhi[3*(p-8) +: 3] = m;
      apb(1'b1, OFS_MODE_HI, mhi);
    end
  endtask

  // sel 0: cycles at lvl, 1: cycles driven, 2: cycles boosted high
  task automatic cnt(int sel, int p, logic lvl, int n);
    c = 0;
    repeat (n) begin
      @(posedge core_clk);
      case (sel)
        0: c += int'(pin_out[p] === lvl);
        1: c += int'(pin_oe[p] === 1'b1);
        default: c += int'(pin_oe[p] === 1'b1 && pin_out[p] === 1'b1);
      endcase
    end
  endtask

  initial begin
    #500_000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    rd_chk("out_value", OFS_OUT_VALUE, 32'h7ff);
    rd_chk("mode_lo", OFS_MODE_LO, 32'h0);
    rd_chk("mode_hi", OFS_MODE_HI, 32'h124);
    check_word("reset_oe", 32'h0, {21'h0, pin_oe});
    check_word("very_weak", 32'h700, {21'h0, pvw});
    rd_chk("unmapped", 8'h2c, 32'h0);
    check_word("slverr", 32'h1, {31'h0, e});
    // output value first, then the mode
    set_ov(5, 1'b0);
    for (int k = 0; k < 5; k++) begin
      set_mode(5, pin_mode_t'(k));
      repeat (2) @(posedge core_clk);
      check_word("mode_oe", {31'h0, k >= 2}, {31'h0, pin_oe[5]});
      check_word("mode_pull", {31'h0, k == 4}, {31'h0, pw[5]});
    end
    set_mode(5, MODE_OPEN_DRAIN);
    set_ov(5, 1'b1);
    for (int v = 0; v < 2; v++) begin
      ext_en[5] <= 1'b1;
      ext_val[5] <= v[0];
      repeat (4) @(posedge core_clk);
      check_word("od_release", 32'h0, {31'h0, pin_oe[5]});
      apb(1'b0, OFS_PIN_STATE, 32'h0);
      check_word("pin_state", v, {31'h0, r[5]});
    end
    set_ov(8, 1'b0);
    set_ov(8, 1'b1);
    cnt(2, 8, 1'b1, 8);
    check_count("quasi_boost", 1, 1, c);
    set_mode(3, MODE_PUSH_PULL);
    for (int v = 0; v < 2; v++) begin
      set_ov(3, v[0]);
      apb(1'b1, OFS_PULSE_CMD, 32'h3);
      cnt(0, 3, ~v[0], 40);
      check_count("pulse", PULSE_CYC, PULSE_CYC, c);
      check_word("pulse_end", v, {31'h0, pin_out[3]});
    end
    for (int p = 2; p < 5; p++) set_mode(p, MODE_PUSH_PULL);
    apb(1'b1, OFS_ALT_CTRL, 32'h700);
    for (int ch = 0; ch < 3; ch++) begin
      apb(1'b1, OFS_DUTY_A + 8'(4 * ch), 32'hc0);
      // old duty still in the pwm and pad registers for two edges
      repeat (2) @(posedge core_clk);
      cnt(0, 2 + ch, 1'b1, 256);
      check_count("pwm_channel", 64, 64, c);
    end
    for (int k = 0; k < 4; k++) begin
      dv = (k == 0) ? 32'h00 : (k == 1) ? 32'h40 : (k == 2) ? 32'h80 : 32'hff;
      apb(1'b1, OFS_DUTY_A, dv);
      repeat (2) @(posedge core_clk);
      cnt(0, 2, 1'b1, 256);
      check_count("pwm_duty", 256 - dv, 256 - dv, c);
    end
    apb(1'b1, OFS_DUTY_C, 32'h0);
    set_ov(4, 1'b0);
    apb(1'b1, OFS_ALT_CTRL, 32'hc00);
    repeat (2) @(posedge core_clk);
    cnt(0, 4, 1'b1, 256);
    check_count("pwm_c_uart", 0, 0, c);
    set_mode(7, MODE_PUSH_PULL);
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, OFS_ALT_CTRL, {30'h0, f[0], 1'b1});
      c = 0;
      repeat (1000) begin
        @(posedge core_clk);
        r[0] = pin_out[7];
        #1;
        c += int'(pin_out[7] === 1'b1 && r[0] === 1'b0);
      end
      check_count("clk_edges", 59 + 60 * f, 61 + 60 * f, c);
    end
    set_mode(7, MODE_DISABLED);
    repeat (2) @(posedge core_clk);
    cnt(1, 7, 1'b1, 50);
    check_count("clk_disabled", 0, 0, c);
    set_mode(1, MODE_PUSH_PULL);
    usb_suspend <= 1'b1;
    for (int pol = 0; pol < 2; pol++) begin
      set_ov(1, ~pol[0]);
      apb(1'b1, OFS_ALT_CTRL, 32'h4 | (pol << 3));
      repeat (4) @(posedge core_clk);
      check_word("suspend_ind", pol, {31'h0, pin_out[1]});
    end
    set_mode(6, MODE_INPUT);
    set_mode(4, MODE_INPUT);
    ext_en <= 11'h050;
    for (int k = 0; k < 4; k++) begin
      // k bit 0 picks input a or b, k bit 1 the active level
      apb(1'b1, OFS_ALT_CTRL, (32'h10 | ((k >> 1) << 5)) << (2 * (k & 1)));
      ext_val <= (k >> 1) ? 11'h000 : 11'h050;
      repeat (5) @(posedge core_clk);
      check_word("wake_idle", 32'h0, {31'h0, remote_wakeup});
      ext_val <= (k >> 1) ? 11'h050 : 11'h000;
      repeat (5) @(posedge core_clk);
      check_word("wake_act", 32'h1, {31'h0, remote_wakeup});
    end
    usb_suspend <= 1'b0;
    repeat (3) @(posedge core_clk);
    check_word("wake_awake", 32'h0, {31'h0, remote_wakeup});
    set_mode(0, MODE_INPUT);
    ext_en[0] <= 1'b1;
    ext_val[0] <= 1'b0;
    apb(1'b1, OFS_CHG_ENABLE, 32'h1);
    apb(1'b1, OFS_CHG_EVENTS, 32'hff);
    ext_val[0] <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd_chk("chg_events", OFS_CHG_EVENTS, 32'h1);
    check_word("chg_pend", 32'h1, {31'h0, pin_change_pending});
    apb(1'b1, OFS_CHG_EVENTS, 32'h1);
    repeat (3) @(posedge core_clk);
    rd_chk("chg_clear", OFS_CHG_EVENTS, 32'h0);
    rd_chk("mode_hi_end", OFS_MODE_HI, 32'h124);
    report_and_stop();
  end
endmodule

// *** gpio_pad_model.sv ***
`timescale 1ns/1ns
module gpio_pad_model
  import gpio_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic [gpio_port_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [gpio_port_pkg::NUM_PINS-1:0] pin_oe,
  input wire logic [gpio_port_pkg::NUM_PINS-1:0] pull_en,
  input wire logic [gpio_port_pkg::NUM_PINS-1:0] ext_en,
  input wire logic [gpio_port_pkg::NUM_PINS-1:0] ext_val,
  output logic [gpio_port_pkg::NUM_PINS-1:0] pad
);
  // a floating pad wanders every cycle so no stale level reads back
  logic flt = 1'b0;
  always @(posedge core_clk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_oe[i]) pad[i] = pin_out[i];
      else if (ext_en[i]) pad[i] = ext_val[i];
      else if (pull_en[i]) pad[i] = 1'b1;
      else pad[i] = flt ^ i[0];
    end
  end
endmodule

// *** gpio_port.sv ***
// Function
// - stored output values reset to one
// - pins 0-7 disabled, 8-10 quasi at reset
// - five configurations selectable on every pin
// - open-drain high releases line, reads input
// - weak and very weak pull-ups enabled
// - quasi pins drive high one cycle only
// - pin state read returns actual level
// - clock output on pin seven, 6/12 MHz
// - disabled pin seven shows no clock
// - suspend indicator with selectable polarity
// - wakeup inputs trigger remote wakeup
// - per-pin change events on pins 0-7
// - single pulse opposite current level
// - pulse width at least 200 ns
// - three 8-bit pwm on pins 2-4
// - uart enable disables pwm channel c
// - high fraction is one minus duty/256
`timescale 1ns/1ns
module gpio_port
  import gpio_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usb_suspend,
  input wire logic [gpio_port_pkg::NUM_PINS-1:0] pin_in,
  output logic [gpio_port_pkg::NUM_PINS-1:0] pin_out,
  output logic [gpio_port_pkg::NUM_PINS-1:0] pin_oe,
  output logic [gpio_port_pkg::NUM_PINS-1:0] pull_weak_en,
  output logic [gpio_port_pkg::NUM_PINS-1:0] pull_very_weak_en,
  output logic remote_wakeup,
  output logic pin_change_pending
);

  logic [NUM_PINS-1:0] out_value;
  pin_mode_t mode [NUM_PINS];
  logic [ALT_W-1:0] alt_ctrl;
  logic [CHG_PINS-1:0] chg_enable;
  logic [CHG_PINS-1:0] chg_events;
  logic [7:0] duty [PWM_CH];
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;
  logic [CHG_PINS-1:0] pin_prev;
  logic [CKO_ACC_W-1:0] cko_acc;
  logic cko_level;
  logic pulse_active;
  logic [PULSE_CNT_W-1:0] pulse_cnt;
  logic [PIN_IDX_W-1:0] pulse_pin;
  logic [NUM_PINS-1:0] last_eff;
  logic [PWM_CH-1:0] pwm_raw;
  logic [PWM_CH-1:0] pwm_drive;
  logic [NUM_PINS-1:0] eff;
  logic [NUM_PINS-1:0] next_out;
  logic [NUM_PINS-1:0] next_oe;
  logic [NUM_PINS-1:0] next_pull;
  logic [31:0] next_rdata;
  logic next_err;
  logic setup;
  logic wr_en;
  logic [CHG_PINS-1:0] chg_seen;
  logic [CHG_PINS-1:0] chg_clear;
  logic pulse_req;
  logic [PULSE_CNT_W:0] pulse_seen;

  function automatic pin_mode_t reset_mode(input int i);
    return QUASI_MASK[i] ? MODE_OD_PULLUP : MODE_DISABLED;
  endfunction

  function automatic logic is_output(input pin_mode_t m);
    return m == MODE_PUSH_PULL || m == MODE_OPEN_DRAIN
      || m == MODE_OD_PULLUP;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == OFS_OUT_VALUE || a == OFS_MODE_LO || a == OFS_MODE_HI
      || a == OFS_PIN_STATE || a == OFS_ALT_CTRL || a == OFS_CHG_ENABLE
      || a == OFS_CHG_EVENTS || a == OFS_PULSE_CMD || a == OFS_DUTY_A
      || a == OFS_DUTY_B || a == OFS_DUTY_C;
  endfunction

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  // one wait-free access cycle; answer prepared in the setup cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && next_err;
      prdata <= (setup && !pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = !mapped(paddr);
    case (paddr)
      OFS_OUT_VALUE: next_rdata[NUM_PINS-1:0] = out_value;
      OFS_MODE_LO: begin
        for (int i = 0; i < MODE_HI_BASE; i++) begin
          next_rdata[i*MODE_W +: MODE_W] = mode[i];
        end
      end
      OFS_MODE_HI: begin
        for (int i = MODE_HI_BASE; i < NUM_PINS; i++) begin
          next_rdata[(i-MODE_HI_BASE)*MODE_W +: MODE_W] = mode[i];
        end
      end
      OFS_PIN_STATE: next_rdata[NUM_PINS-1:0] = pin_sync;
      OFS_ALT_CTRL: next_rdata[ALT_W-1:0] = alt_ctrl;
      OFS_CHG_ENABLE: next_rdata[CHG_PINS-1:0] = chg_enable;
      OFS_CHG_EVENTS: next_rdata[CHG_PINS-1:0] = chg_events;
      OFS_PULSE_CMD: begin
        next_rdata[PIN_IDX_W-1:0] = pulse_pin;
        next_rdata[PIN_IDX_W] = pulse_active;
      end
      OFS_DUTY_A: next_rdata[7:0] = duty[0];
      OFS_DUTY_B: next_rdata[7:0] = duty[1];
      OFS_DUTY_C: next_rdata[7:0] = duty[2];
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_value <= OUT_VALUE_RESET;
    end else if (wr_en && paddr == OFS_OUT_VALUE) begin
      out_value <= pwdata[NUM_PINS-1:0];
    end
  end

  // unknown mode codes are ignored so a pin never lands in a bad state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        mode[i] <= reset_mode(i);
      end
    end else if (wr_en) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (i < MODE_HI_BASE && paddr == OFS_MODE_LO &&
            pwdata[i*MODE_W +: MODE_W] <= MODE_OD_PULLUP) begin
          mode[i] <= pin_mode_t'(pwdata[i*MODE_W +: MODE_W]);
        end
        if (i >= MODE_HI_BASE && paddr == OFS_MODE_HI &&
            pwdata[(i-MODE_HI_BASE)*MODE_W +: MODE_W] <= MODE_OD_PULLUP)
        begin
          mode[i] <= pin_mode_t'(
            pwdata[(i-MODE_HI_BASE)*MODE_W +: MODE_W]);
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      alt_ctrl <= '0;
      chg_enable <= '0;
      for (int c = 0; c < PWM_CH; c++) begin
        duty[c] <= 8'h00;
      end
    end else if (wr_en) begin
      case (paddr)
        OFS_ALT_CTRL: alt_ctrl <= pwdata[ALT_W-1:0];
        OFS_CHG_ENABLE: chg_enable <= pwdata[CHG_PINS-1:0];
        OFS_DUTY_A: duty[0] <= pwdata[7:0];
        OFS_DUTY_B: duty[1] <= pwdata[7:0];
        OFS_DUTY_C: duty[2] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // pins are asynchronous; only pin_sync is read by logic
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync[CHG_PINS-1:0];
    end
  end

  // change events: a new change beats a same-cycle write-one clear
  assign chg_seen = (pin_sync[CHG_PINS-1:0] ^ pin_prev) & chg_enable;
  assign chg_clear = (wr_en && paddr == OFS_CHG_EVENTS) ?
    pwdata[CHG_PINS-1:0] : '0;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      chg_events <= '0;
      pin_change_pending <= 1'b0;
    end else begin
      chg_events <= (chg_events & ~chg_clear) | chg_seen;
      pin_change_pending <= |((chg_events & ~chg_clear) | chg_seen);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      remote_wakeup <= 1'b0;
    end else begin
      remote_wakeup <= usb_suspend &&
        ((alt_ctrl[ALT_WAKE_A_EN] &&
          pin_sync[PIN_WAKE_A] == alt_ctrl[ALT_WAKE_A_POL]) ||
         (alt_ctrl[ALT_WAKE_B_EN] &&
          pin_sync[PIN_WAKE_B] == alt_ctrl[ALT_WAKE_B_POL]));
    end
  end

  // 100 MHz does not divide to 12 MHz, so edges carry one cycle of jitter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cko_acc <= '0;
      cko_level <= 1'b0;
    end else begin
      {cko_level, cko_acc} <= {1'b0, cko_acc}
        + {1'b0, alt_ctrl[ALT_CKO_FAST] ? CKO_INC_FAST : CKO_INC_SLOW}
        + {cko_level, {CKO_ACC_W{1'b0}}};
    end
  end

  // a command for a non-output pin or during a pulse is dropped
  assign pulse_req = wr_en && paddr == OFS_PULSE_CMD && !pulse_active
    && pwdata[PIN_IDX_W-1:0] < PIN_IDX_W'(NUM_PINS)
    && is_output(mode[pwdata[PIN_IDX_W-1:0]]);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_active <= 1'b0;
      pulse_cnt <= '0;
      pulse_pin <= '0;
    end else if (pulse_req) begin
      pulse_active <= 1'b1;
      pulse_cnt <= PULSE_CNT_W'(PULSE_CYC - 1);
      pulse_pin <= pwdata[PIN_IDX_W-1:0];
    end else if (pulse_active) begin
      pulse_cnt <= pulse_cnt - 1'b1;
      pulse_active <= pulse_cnt != '0;
    end
  end

  for (genvar c = 0; c < PWM_CH; c++) begin : g_pwm
    pwm_channel u_pwm (
      .core_clk(core_clk),
      .rstn(rstn),
      .duty(duty[c]),
      .pwm_out(pwm_raw[c])
    );
  end

  always_comb begin
    pwm_drive = pwm_raw & alt_ctrl[ALT_PWM_EN +: PWM_CH];
    pwm_drive[PWM_C_IDX] = pwm_drive[PWM_C_IDX]
      && !alt_ctrl[ALT_UART_EN];
  end

  // alternate functions override the stored value on their pins
  always_comb begin
    eff = out_value;
    for (int c = 0; c < PWM_CH; c++) begin
      if (alt_ctrl[ALT_PWM_EN + c] &&
          !(c == PWM_C_IDX && alt_ctrl[ALT_UART_EN])) begin
        eff[PIN_PWM_A + c] = pwm_drive[c];
      end
    end
    if (alt_ctrl[ALT_SUSP_EN]) begin
      eff[PIN_SUSP] = usb_suspend ~^ alt_ctrl[ALT_SUSP_POL];
    end
    if (alt_ctrl[ALT_CKO_EN]) begin
      eff[PIN_CKO] = cko_level;
    end
    if (pulse_active) begin
      eff[pulse_pin] = !out_value[pulse_pin];
    end
  end

  always_comb begin
    next_out = '0;
    next_oe = '0;
    next_pull = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      case (mode[i])
        MODE_DISABLED: next_oe[i] = 1'b0;
        MODE_INPUT: next_oe[i] = 1'b0;
        MODE_PUSH_PULL: begin
          next_oe[i] = 1'b1;
          next_out[i] = eff[i];
        end
        MODE_OPEN_DRAIN: next_oe[i] = !eff[i];
        MODE_OD_PULLUP: begin
          next_pull[i] = 1'b1;
          if (QUASI_MASK[i] && eff[i] && !last_eff[i]) begin
            next_oe[i] = 1'b1;
            next_out[i] = 1'b1;
          end else begin
            next_oe[i] = !eff[i];
          end
        end
        default: next_oe[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_out <= '0;
      pin_oe <= '0;
      pull_weak_en <= QUASI_MASK;
      pull_very_weak_en <= QUASI_MASK;
      last_eff <= OUT_VALUE_RESET;
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      pull_weak_en <= next_pull;
      pull_very_weak_en <= next_pull;
      last_eff <= eff;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_seen <= '0;
    end else begin
      pulse_seen <= pulse_active ? pulse_seen + 1'b1 : '0;
    end
  end

  property p_pulse_width;
    @(posedge core_clk) disable iff (!rstn)
    $fell(pulse_active) |-> $past(pulse_seen) >= (PULSE_MIN_CYC - 1);
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("single pulse shorter than minimum");

  property p_quasi_one_cycle;
    @(posedge core_clk) disable iff (!rstn)
    (mode[8] == MODE_OD_PULLUP && pin_oe[8] && pin_out[8])
      |=> !(pin_oe[8] && pin_out[8]);
  endproperty
  a_quasi_one_cycle: assert property (p_quasi_one_cycle)
    else $error("quasi pin driven high more than one cycle");

  property p_disabled_floats;
    @(posedge core_clk) disable iff (!rstn)
    mode[PIN_CKO] == MODE_DISABLED |=> !pin_oe[PIN_CKO];
  endproperty
  a_disabled_floats: assert property (p_disabled_floats)
    else $error("disabled pin seven is driven");

  property p_od_never_high;
    @(posedge core_clk) disable iff (!rstn)
    mode[5] == MODE_OPEN_DRAIN |=> !(pin_oe[5] && pin_out[5]);
  endproperty
  a_od_never_high: assert property (p_od_never_high)
    else $error("open-drain pin drives high");

  property p_pwm_c_off;
    @(posedge core_clk) disable iff (!rstn)
    (alt_ctrl[ALT_UART_EN] && mode[PIN_WAKE_B] == MODE_PUSH_PULL
      && !pulse_active)
      |=> pin_out[PIN_WAKE_B] == $past(out_value[PIN_WAKE_B]);
  endproperty
  a_pwm_c_off: assert property (p_pwm_c_off)
    else $error("pwm channel c active while uart enabled");

  property p_change_event;
    @(posedge core_clk) disable iff (!rstn)
    (chg_enable[0] && pin_sync[0] != pin_prev[0])
      |=> chg_events[0] && pin_change_pending;
  endproperty
  a_change_event: assert property (p_change_event)
    else $error("enabled pin change not recorded");

  property p_wakeup;
    @(posedge core_clk) disable iff (!rstn)
    (usb_suspend && alt_ctrl[ALT_WAKE_A_EN]
      && pin_sync[PIN_WAKE_A] == alt_ctrl[ALT_WAKE_A_POL])
      |=> remote_wakeup;
  endproperty
  a_wakeup: assert property (p_wakeup)
    else $error("wakeup input did not raise remote wakeup");

  property p_suspend_ind;
    @(posedge core_clk) disable iff (!rstn)
    (alt_ctrl[ALT_SUSP_EN] && mode[PIN_SUSP] == MODE_PUSH_PULL
      && !pulse_active)
      |=> pin_out[PIN_SUSP] == ($past(usb_suspend)
        ~^ $past(alt_ctrl[ALT_SUSP_POL]));
  endproperty
  a_suspend_ind: assert property (p_suspend_ind)
    else $error("suspend indicator level wrong");

  property p_pulse_inverts;
    @(posedge core_clk) disable iff (!rstn)
    (pulse_active && pulse_pin == 4'h3 && mode[3] == MODE_PUSH_PULL)
      |=> pin_out[3] == !$past(out_value[3]);
  endproperty
  a_pulse_inverts: assert property (p_pulse_inverts)
    else $error("single pulse not opposite to output value");

endmodule

// *** gpio_port_pkg.sv ***
package gpio_port_pkg;

  localparam int NUM_PINS = 11;
  localparam int CHG_PINS = 8;
  localparam int MODE_W = 3;
  localparam int PWM_CH = 3;

  typedef enum logic [2:0] {
    MODE_DISABLED,
    MODE_INPUT,
    MODE_PUSH_PULL,
    MODE_OPEN_DRAIN,
    MODE_OD_PULLUP
  } pin_mode_t;

  // register byte offsets
  localparam logic [7:0] OFS_OUT_VALUE = 8'h00;
  localparam logic [7:0] OFS_MODE_LO = 8'h04;
  localparam logic [7:0] OFS_MODE_HI = 8'h08;
  localparam logic [7:0] OFS_PIN_STATE = 8'h0c;
  localparam logic [7:0] OFS_ALT_CTRL = 8'h10;
  localparam logic [7:0] OFS_CHG_ENABLE = 8'h14;
  localparam logic [7:0] OFS_CHG_EVENTS = 8'h18;
  localparam logic [7:0] OFS_PULSE_CMD = 8'h1c;
  localparam logic [7:0] OFS_DUTY_A = 8'h20;
  localparam logic [7:0] OFS_DUTY_B = 8'h24;
  localparam logic [7:0] OFS_DUTY_C = 8'h28;

  localparam logic [10:0] OUT_VALUE_RESET = 11'h7ff;
  localparam logic [10:0] QUASI_MASK = 11'h700;
  localparam int MODE_HI_BASE = 8;

  // alternate control field positions
  localparam int ALT_CKO_EN = 0;
  localparam int ALT_CKO_FAST = 1;
  localparam int ALT_SUSP_EN = 2;
  localparam int ALT_SUSP_POL = 3;
  localparam int ALT_WAKE_A_EN = 4;
  localparam int ALT_WAKE_A_POL = 5;
  localparam int ALT_WAKE_B_EN = 6;
  localparam int ALT_WAKE_B_POL = 7;
  localparam int ALT_PWM_EN = 8;
  localparam int ALT_UART_EN = 11;
  localparam int ALT_W = 12;

  // pin assignment of alternate functions
  localparam int PIN_CKO = 7;
  localparam int PIN_SUSP = 1;
  localparam int PIN_WAKE_A = 6;
  localparam int PIN_WAKE_B = 4;
  localparam int PIN_PWM_A = 2;
  localparam int PWM_C_IDX = 2;

  // timing
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_TYP_NS = 250;
  localparam int PULSE_MIN_NS = 200;
  localparam int PULSE_CYC =
    (PULSE_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MIN_CYC =
    (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = 5;
  localparam int PIN_IDX_W = 4;

  // clock output by phase accumulator: one carry per half period
  localparam int CKO_ACC_W = 24;
  localparam longint unsigned CKO_ACC_ONE = 64'h1 << CKO_ACC_W;
  localparam longint unsigned CKO_FAST_HZ = 12_000_000;
  localparam longint unsigned CKO_SLOW_HZ = 6_000_000;
  localparam logic [CKO_ACC_W-1:0] CKO_INC_FAST =
    CKO_ACC_W'((2 * CKO_FAST_HZ * CKO_ACC_ONE) / CLK_HZ);
  localparam logic [CKO_ACC_W-1:0] CKO_INC_SLOW =
    CKO_ACC_W'((2 * CKO_SLOW_HZ * CKO_ACC_ONE) / CLK_HZ);

endpackage

// *** pwm_channel.sv ***
`timescale 1ns/1ns
module pwm_channel
  import gpio_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] duty,
  output logic pwm_out
);

  logic [7:0] cnt;

  // free-running period of 256 counts
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // duty 0 keeps the output high all period
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pwm_out <= 1'b1;
    end else begin
      pwm_out <= (cnt >= duty);
    end
  end

  property p_pwm_compare;
    @(posedge core_clk) disable iff (!rstn)
    ##1 pwm_out == ($past(cnt) >= $past(duty));
  endproperty
  a_pwm_compare: assert property (p_pwm_compare)
    else $error("pwm output does not follow counter compare");

endmodule
